// ==== bench/adc_sequencer_trigger_select_asserts.sv ====
// Port-level assertions for the trigger selector.
`include "trig_sel_defs.svh"
module adc_sequencer_trigger_select_asserts
   import trig_sel_pkg::*;
#(
   parameter int NUM_SEQ = 3
) (
   // Clock and reset.
   input wire logic               core_clk_i,
   input wire logic               rst_i,
   // Bus.
   input wire logic               psel_i,
   input wire logic               penable_i,
   input wire logic               pwrite_i,
   input wire logic [11:0]        paddr_i,
   input wire logic [31:0]        prdata_o,
   input wire logic               pready_o,
   input wire logic               pslverr_o,
   // Run control.
   input wire logic               seq_busy_i,
   input wire logic [NUM_SEQ-1:0] seq_start_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   chk_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
      else $error("no ready after access");
   chk_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready too long");
   chk_err_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
   chk_err_zero: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
      else $error("refused read not zero");
   chk_select_mapped: assert property (pready_o && paddr_i == `TRIG_SEL_OFFSET |-> !pslverr_o)
      else $error("select register refused");
   chk_start_onehot: assert property ($onehot0(seq_start_o)) else $error("two starts");
   chk_start_gap: assert property (|seq_start_o |=> seq_start_o == '0)
      else $error("starts adjacent");
   chk_busy_stall: assert property (seq_busy_i |=> seq_start_o == '0)
      else $error("start while busy");
   chk_reset_quiet: assert property ($fell(rst_i) |-> !pready_o && seq_start_o == '0)
      else $error("outputs active after reset");
endmodule : adc_sequencer_trigger_select_asserts
bind adc_sequencer_trigger_select adc_sequencer_trigger_select_asserts #(.NUM_SEQ(NUM_SEQ)) chk_i (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .seq_busy_i(seq_busy_i), .seq_start_o(seq_start_o));

// ==== bench/test_adc_sequencer_trigger_select.sv ====
// Self-checking bench for the trigger selector.
`include "trig_sel_defs.svh"
module test_adc_sequencer_trigger_select;
   import trig_sel_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, busy = 0, ote = 0, rdy, serr, err;
   logic [11:0] paddr = '0, ord;
   logic [31:0] pwdata = '0, prdata, q;
   logic [3:0]  src = '0;
   logic [2:0]  start;
   trig_events_t ev;
   int failures = 0, total_checks = 0;
   always #20 clk = ~clk;
   trig_src_model src_m (.core_clk_i(clk), .src_i(src), .timer_ote_i(ote), .events_o(ev));
   adc_sequencer_trigger_select uut (.core_clk_i(clk), .rst_i(rst), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(rdy), .pslverr_o(serr), .events_i(ev),
      .seq_busy_i(busy), .seq_start_o(start));
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (rdy !== 1'b1);
      q = prdata;
      err = serr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic pulse(logic [3:0] m);
      @(posedge clk);
      src <= m;
      @(posedge clk);
      src <= 0;
   endtask : pulse
   // Collects the starts seen, oldest in the upper bits.
   task automatic watch(int n);
      ord = '0;
      repeat (n) begin
         @(posedge clk);
         #1;
         if (start !== 3'b000) ord = {ord[8:0], start};
      end
   endtask : watch
   task automatic t_regs;
      apb(0, `TRIG_SEL_OFFSET, 0);
      chk("select reset", q, `TRIG_SEL_RESET);
      apb(0, `PRIORITY_OFFSET, 0);
      chk("priority reset", q, `PRIORITY_RESET);
      apb(1, `TRIG_SEL_OFFSET, 32'h0000_0412);
      apb(0, `TRIG_SEL_OFFSET, 0);
      chk("select rw", q, 32'h0000_0412);
      pulse(4'h8);
      watch(8);
      chk("comp0 to seq1 only", ord, 12'h002);
      pulse(4'h2);
      watch(8);
      chk("pin to seq2 only", ord, 12'h004);
      apb(0, 12'h100, 0);
      chk("unmapped err", err, 1);
      chk("unmapped data", q, 0);
   endtask : t_regs
   task automatic t_codes;
      logic [3:0] code[10] = '{1, 2, 4, 5, 5, 3, 6, 8, 4'he, 4'hf};
      logic [3:0] msk[10] = '{8, 4, 2, 1, 1, 15, 15, 15, 15, 0};
      logic       oe[10] = '{0, 0, 0, 1, 0, 1, 1, 1, 1, 0};
      logic       hit[10] = '{1, 1, 1, 1, 0, 0, 0, 0, 0, 1};
      apb(1, `TRIG_SEL_OFFSET, 32'h0000_0330);
      apb(1, `INITIATE_OFFSET, 1);
      watch(8);
      chk("software start", ord, 12'h001);
      for (int i = 0; i < 10; i++) begin
         ote <= oe[i];
         apb(1, `TRIG_SEL_OFFSET, {28'h000_0033, code[i]});
         pulse(msk[i]);
         watch(8);
         chk("seq0 start", |ord, hit[i]);
         chk("other seqs quiet", ord & 12'hdb6, 0);
      end
   endtask : t_codes
   task automatic t_prio;
      apb(1, `TRIG_SEL_OFFSET, 0);
      watch(8);
      apb(1, `PRIORITY_OFFSET, 32'h0000_0012);
      @(posedge clk);
      busy <= 1;
      apb(1, `INITIATE_OFFSET, 32'h7);
      watch(6);
      chk("stalled while busy", ord, 0);
      @(posedge clk);
      busy <= 0;
      watch(12);
      chk("grant order", ord, 12'h111);
   endtask : t_prio
   task automatic end_of_test;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (4) @(posedge clk);
      rst <= 0;
      t_regs();
      t_codes();
      t_prio();
      end_of_test();
   end
   initial begin
      #100us;
      failures++;
      end_of_test();
   end
endmodule : test_adc_sequencer_trigger_select

// ==== bench/trig_src_model.sv ====
// Behavioural model of the comparator, timer and pin trigger sources.
module trig_src_model
   import trig_sel_pkg::*;
(
   // Clock.
   input  wire logic          core_clk_i,
   // Source activity: comparator 0, comparator 1, pin, timer.
   input  wire logic [3:0]    src_i,
   input  wire logic          timer_ote_i,
   // Event lines.
   output trig_sel_pkg::trig_events_t events_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import trig_sel_pkg::*;
   trig_events_t ev_r;
   always_ff @(posedge core_clk_i) begin
      ev_r <= {src_i[3:1], src_i[0] & timer_ote_i};
   end
   assign events_o = ev_r;
endmodule : trig_src_model

// ==== hw/adc_sequencer_trigger_select.sv ====
// Trigger-source selection and start arbitration for sample sequencers 0 to 2.
// Function
// - A 4-bit read/write field at bits 11:8 of the selection register picks sequencer 2's trigger.
// - A 4-bit read/write field at bits 7:4 picks sequencer 1's trigger.
// - A 4-bit read/write field at bits 3:0 picks sequencer 0's trigger, and all fields reset to 0.
// - Codes 0 software, 1 comparator 0, 2 comparator 1, 4 external pin, f continuous sampling.
// - Code 5 starts on the timer event, which the timer gives only with its trigger enable set.
// - The selection register is at offset 014, resets to zero, and each sequencer chooses freely.
// - Sequencers triggered together run in the order of their programmed priority values.
//
// The APB slave port and the register offsets were decided locally.
`include "trig_sel_defs.svh"
module adc_sequencer_trigger_select
   import trig_sel_pkg::*;
#(
   parameter int NUM_SEQ = 3
) (
   // Clock and reset.
   input  wire logic                  core_clk_i,
   input  wire logic                  rst_i,
   // APB slave.
   input  wire logic                  psel_i,
   input  wire logic                  penable_i,
   input  wire logic                  pwrite_i,
   input  wire logic [11:0]           paddr_i,
   input  wire logic [31:0]           pwdata_i,
   output logic [31:0]                prdata_o,
   output logic                       pready_o,
   output logic                       pslverr_o,
   // Trigger event lines.
   input  wire trig_sel_pkg::trig_events_t events_i,
   // Sequencer run control.
   input  wire logic                  seq_busy_i,
   output logic [NUM_SEQ-1:0]         seq_start_o
);
   import trig_sel_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   apb_req_t            req;
   logic [11:0]         sel_r;
   logic [11:0]         sel_nxt;
   logic [5:0]          prio_r;
   logic [5:0]          prio_nxt;
   logic [NUM_SEQ-1:0]  sw_r;
   logic [NUM_SEQ-1:0]  sw_nxt;
   logic [NUM_SEQ-1:0]  pend_r;
   logic [NUM_SEQ-1:0]  pend_nxt;
   logic [NUM_SEQ-1:0]  start_r;
   logic [NUM_SEQ-1:0]  start_nxt;
   logic [NUM_SEQ-1:0]  trig;
   logic [31:0]         prdata_r;
   logic [31:0]         prdata_nxt;
   logic                pready_r;
   logic                pready_nxt;
   logic                pslverr_r;
   logic                pslverr_nxt;
   arb_state_t          state_r;
   arb_state_t          state_nxt;

   assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i,
                  paddr: paddr_i, pwdata: pwdata_i};

   // The four registers that answer without an error.
   function automatic logic addr_known(input logic [11:0] a);
      addr_known = (a == `TRIG_SEL_OFFSET) || (a == `PRIORITY_OFFSET) ||
                   (a == `INITIATE_OFFSET) || (a == `STATUS_OFFSET);
   endfunction : addr_known

   ////////////////////////////////////////////////////////////////////////////////
   // Priority fields are two bits wide and sit four bits apart in the register word.
   // Software sees that layout; inside, the fields are packed tight for the arbiter.
   function automatic logic [5:0] prio_unpack(input logic [31:0] w);
      prio_unpack = '0;
      for (int i = 0; i < NUM_SEQ; i++) begin
         prio_unpack[i*`PRIO_WIDTH +: `PRIO_WIDTH] = w[i*`PRIO_FIELD_STRIDE +: `PRIO_WIDTH];
      end
   endfunction : prio_unpack

   function automatic logic [31:0] prio_pack(input logic [5:0] p);
      prio_pack = '0;
      for (int i = 0; i < NUM_SEQ; i++) begin
         prio_pack[i*`PRIO_FIELD_STRIDE +: `PRIO_WIDTH] = p[i*`PRIO_WIDTH +: `PRIO_WIDTH];
      end
   endfunction : prio_pack

   localparam logic [5:0] PRIO_RESET_FIELDS = prio_unpack(`PRIORITY_RESET);

   ////////////////////////////////////////////////////////////////////////////////
   // Register bus: one wait state. An access is seen at its first access edge and
   // pready follows a cycle later. A write lands only at the edge that completes the
   // transfer, so a stretched or abandoned access never half-updates a register.
   logic rd_en;
   logic wr_en;
   assign rd_en = req.psel && req.penable && !req.pwrite && !pready_r;
   assign wr_en = req.psel && req.penable && req.pwrite && pready_r;

   always_comb begin
      sel_nxt     = sel_r;
      prio_nxt    = prio_r;
      sw_nxt      = '0;
      prdata_nxt  = prdata_r;
      pready_nxt  = 1'b0;
      pslverr_nxt = 1'b0;
      // An unknown address is refused: its write is dropped and its read returns zero.
      if (req.psel && req.penable && !pready_r) begin
         pready_nxt  = 1'b1;
         pslverr_nxt = !addr_known(req.paddr);
      end
      // Read data is captured one edge ahead so that it stands in the pready cycle.
      if (rd_en) begin
         case (req.paddr)
            `TRIG_SEL_OFFSET: prdata_nxt = {20'h0_0000, sel_r};
            `PRIORITY_OFFSET: prdata_nxt = prio_pack(prio_r);
            // Status shows the pending triggers above the start outputs, which hold a grant for one cycle only.
            `STATUS_OFFSET:   prdata_nxt = {26'h0, pend_r, start_r};
            default:          prdata_nxt = 32'h0000_0000;
         endcase
      end
      if (wr_en) begin
         if (req.paddr == `TRIG_SEL_OFFSET) begin
            sel_nxt = req.pwdata[11:0];
         end
         if (req.paddr == `PRIORITY_OFFSET) begin
            prio_nxt = prio_unpack(req.pwdata);
         end
         if (req.paddr == `INITIATE_OFFSET) begin
            sw_nxt = req.pwdata[NUM_SEQ-1:0];
         end
      end
   end

   // Select and priority fields take their reset values; the initiate bits only
   // ever pulse for one cycle after a completed write.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sel_r     <= 12'(`TRIG_SEL_RESET);
         prio_r    <= PRIO_RESET_FIELDS;
         sw_r      <= '0;
         prdata_r  <= 32'h0000_0000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         sel_r     <= sel_nxt;
         prio_r    <= prio_nxt;
         sw_r      <= sw_nxt;
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One decoder per sequencer, each on its own field.
   // Each decoder registers its request, so an event reaches the pending set
   // two edges after it is seen on the event lines.
   for (genvar g = 0; g < NUM_SEQ; g++) begin : g_dec
      seq_event_decode u_dec (
         .core_clk_i (core_clk_i),
         .rst_i      (rst_i),
         .code_i     (sel_r[g*`CODE_WIDTH +: `CODE_WIDTH]),
         .sw_req_i   (sw_r[g]),
         .events_i   (events_i),
         .start_o    (trig[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pending triggers are granted one at a time, lowest priority value first.
   // Equal priority values fall to the lowest sequencer index.
   function automatic logic [NUM_SEQ-1:0] pick(input logic [NUM_SEQ-1:0] p,
                                               input logic [5:0] pr);
      logic [1:0] best;
      logic       found;
      best  = 2'h3;
      found = 1'b0;
      pick  = '0;
      for (int i = 0; i < NUM_SEQ; i++) begin
         if (p[i] && (!found || pr[i*2 +: 2] < best)) begin
            best  = pr[i*2 +: 2];
            found = 1'b1;
            pick  = '0;
            pick[i] = 1'b1;
         end
      end
   endfunction : pick

   always_comb begin
      // Each grant is followed by one idle cycle, which gives the sequencer time to
      // raise busy before the next grant is weighed. Triggers that arrive meanwhile
      // are held in the pending set, and repeats of one trigger merge.
      pend_nxt  = pend_r | trig;
      start_nxt = '0;
      state_nxt = state_r;
      case (state_r)
         ARB_IDLE: begin
            if (!seq_busy_i && (pend_r != '0)) begin
               start_nxt = pick(pend_r, prio_r);
               pend_nxt  = (pend_r & ~start_nxt) | trig;
               state_nxt = ARB_GRANT;
            end
         end
         ARB_GRANT: begin
            state_nxt = ARB_IDLE;
         end
         default: state_nxt = ARB_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pend_r  <= '0;
         start_r <= '0;
         state_r <= ARB_IDLE;
      end else begin
         pend_r  <= pend_nxt;
         start_r <= start_nxt;
         state_r <= state_nxt;
      end
   end

   // Every output is a register; nothing combinational reaches a pin.
   assign prdata_o    = prdata_r;
   assign pready_o    = pready_r;
   assign pslverr_o   = pslverr_r;
   assign seq_start_o = start_r;
endmodule : adc_sequencer_trigger_select

// ==== hw/seq_event_decode.sv ====
// Per-sequencer trigger decoder: one code field to one start request, registered.
`include "trig_sel_defs.svh"
module seq_event_decode
   import trig_sel_pkg::*;
(
   // Clock and reset.
   input  wire logic          core_clk_i,
   input  wire logic          rst_i,
   // Selection, software request and event lines.
   input  wire logic [3:0]    code_i,
   input  wire logic          sw_req_i,
   input  wire trig_sel_pkg::trig_events_t events_i,
   // Start request.
   output logic               start_o
);
   import trig_sel_pkg::*;

   logic start_r;
   logic start_nxt;

   always_comb begin
      case (code_i)
         `CODE_SOFTWARE: start_nxt = sw_req_i;
         `CODE_COMP0:    start_nxt = events_i.comp0;
         `CODE_COMP1:    start_nxt = events_i.comp1;
         `CODE_PIN:      start_nxt = events_i.pin;
         `CODE_TIMER:    start_nxt = events_i.timer;
         `CODE_ALWAYS:   start_nxt = 1'b1;
         default:        start_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         start_r <= 1'b0;
      end else begin
         start_r <= start_nxt;
      end
   end

   assign start_o = start_r;
endmodule : seq_event_decode

// ==== hw/trig_sel_defs.svh ====
// Register offsets, field positions, reset values and trigger codes of the trigger selector.
`ifndef TRIG_SEL_DEFS_SVH
`define TRIG_SEL_DEFS_SVH
`define TRIG_SEL_OFFSET      12'h014
`define PRIORITY_OFFSET      12'h020
`define INITIATE_OFFSET      12'h028
`define STATUS_OFFSET        12'h030
`define TRIG_SEL_RESET       32'h0000_0000
`define PRIORITY_RESET       32'h0000_0210
`define SEQ0_CODE_LSB        0
`define SEQ1_CODE_LSB        4
`define SEQ2_CODE_LSB        8
`define CODE_WIDTH           4
`define PRIO_WIDTH           2
`define PRIO_FIELD_STRIDE    4
`define CODE_SOFTWARE        4'h0
`define CODE_COMP0           4'h1
`define CODE_COMP1           4'h2
`define CODE_PIN             4'h4
`define CODE_TIMER           4'h5
`define CODE_ALWAYS          4'hf
`endif

// ==== hw/trig_sel_pkg.sv ====
// Types shared by the trigger selector files.
package trig_sel_pkg;
   typedef struct packed {
      logic comp0;
      logic comp1;
      logic pin;
      logic timer;
   } trig_events_t;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef enum logic [1:0] {ARB_IDLE, ARB_GRANT} arb_state_t;
endpackage : trig_sel_pkg
